// ### core/rsc_pkg.sv
// Overview of operation
// - Bit 5 write enables or disables comparator reset.
// - Enabled comparator resets when plus below minus.
// - Bit 5 reads 1 only after comparator reset.
// - Comparator reset works asleep if wake-enabled.
// - Watchdog comes up enabled, clocked at clock/12.
// - Watchdog overflow resets and sets bit 3.
// - Watchdog reset suspended in sleep, setting kept.
// - Flash write above lock byte forces reset.
// - Code read or branch above lock resets.
// - Security block or unmonitored flash write resets.
// - Bit 6 flags flash error; writes ignored.
// - Clock fail or alarm match requests reset.
// - Bit 7 enables clock-block reset, flags cause.
// - Clock-block reset stays working in sleep.
// - Writing bit 4 forces reset; then reads 1.
// - Internal resets never touch the reset pin.
// - Bit 2 enables clock-loss detector, flags timeout.
// - Bit 1 flags power reset, enables supply monitor.
// - Bit 0 reads 1 after reset-pin reset.
// - Register is not safe for read-modify-write.
package rsc_pkg;

    localparam logic [7:0] RSC_SFR_ADDR   = 8'hef;
    localparam int         RSC_ADDR_W     = 16;
    localparam int         RSC_RTC_W      = 32;
    localparam int         RSC_WDT_DIV    = 12;
    localparam int         RSC_CLK_NS     = 100;
    localparam int         RSC_HOLD_NS    = 1000;
    localparam int         RSC_HOLD_CYC   = (RSC_HOLD_NS + RSC_CLK_NS - 1) / RSC_CLK_NS;
    localparam logic [7:0] RSC_RDATA_IDLE = 8'h00;

    // Field order follows the register bits 7 down to 0.
    typedef struct packed {
        logic rtc;
        logic flash;
        logic cmp;
        logic sw;
        logic wdt;
        logic clock_loss_detector;
        logic por;
        logic pin;
    } rsc_cause_t;

    localparam rsc_cause_t RSC_CAUSE_NONE = '0;
    localparam rsc_cause_t RSC_CAUSE_POR  = '{por: 1'b1, default: 1'b0};

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rsc_sfr_t;

    typedef struct packed {
        logic                  wr_en;
        logic                  xdata_wr;
        logic [RSC_ADDR_W-1:0] xdata_addr;
        logic                  code_rd;
        logic                  branch;
        logic [RSC_ADDR_W-1:0] code_addr;
        logic                  sec_block;
        logic                  wr_erase;
    } rsc_flash_t;

    typedef struct packed {
        logic                 mcd_en;
        logic                 clk_slow;
        logic                 alarm_en;
        logic [RSC_RTC_W-1:0] timer;
        logic [RSC_RTC_W-1:0] alarm;
    } rsc_rtc_t;

    typedef enum logic [1:0] {
        RSC_ST_RUN  = 2'b01,
        RSC_ST_HOLD = 2'b10
    } rsc_state_t;

endpackage

// ### core/rsc_wdt_clock.sv
`timescale 1ns/100ps
module rsc_wdt_clock #(
    parameter int DIV = rsc_pkg::RSC_WDT_DIV
) (
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_nrst,
    input  wire logic i_sys_rst,
    // Enable control
    input  wire logic i_en_wr,
    input  wire logic i_en_val,
    input  wire logic i_low_power,
    // Watchdog outputs
    output logic      o_enable,
    output logic      o_active,
    output logic      o_tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    if (DIV < 2) begin : g_chk
        $error("Watchdog divider must be at least two.");
    end

    logic [CW-1:0] cnt_reg;
    logic          en_reg;
    logic          tick_reg;
    wire           wrap = (cnt_reg == LAST);

    always_ff @(posedge i_clock) begin
        if (!i_nrst || i_sys_rst) begin
            cnt_reg  <= '0;
            en_reg   <= 1'b1;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= wrap ? '0 : cnt_reg + 1'b1;
            tick_reg <= wrap;
            if (i_en_wr) begin
                en_reg <= i_en_val;
            end
        end
    end

    // Sleep only masks the request; the stored setting survives it.
    assign o_enable = en_reg;
    assign o_active = en_reg & ~i_low_power;
    assign o_tick   = tick_reg;
endmodule

// ### core/rsc_cause_pick.sv
`timescale 1ns/100ps
module rsc_cause_pick (
    // Requests in, single winner out
    input  rsc_pkg::rsc_cause_t i_req,
    output rsc_pkg::rsc_cause_t o_pick
);
    // Only one cause is recorded, so simultaneous requests are ranked.
    function automatic rsc_pkg::rsc_cause_t pick(input rsc_pkg::rsc_cause_t r);
        rsc_pkg::rsc_cause_t p;
        p = rsc_pkg::RSC_CAUSE_NONE;
        if (r.pin) p.pin = 1'b1;
        else if (r.por) p.por = 1'b1;
        else if (r.clock_loss_detector) p.clock_loss_detector = 1'b1;
        else if (r.wdt) p.wdt = 1'b1;
        else if (r.flash) p.flash = 1'b1;
        else if (r.sw) p.sw = 1'b1;
        else if (r.cmp) p.cmp = 1'b1;
        else if (r.rtc) p.rtc = 1'b1;
        return p;
    endfunction

    assign o_pick = pick(i_req);
endmodule

// ### core/rsc_reset_source_controller.sv
`timescale 1ns/100ps
module rsc_reset_source_controller #(
    parameter int HOLD_CYC = rsc_pkg::RSC_HOLD_CYC,
    parameter int WDT_DIV  = rsc_pkg::RSC_WDT_DIV
) (
    // Clock and power-on reset
    input  wire logic                        i_clock,
    input  wire logic                        i_nrst,
    // Special-function register port
    input  rsc_pkg::rsc_sfr_t                i_sfr,
    output logic [7:0]                       o_sfr_rdata,
    // Comparator
    input  wire logic                        i_cmp_out,
    input  wire logic                        i_cmp_wake_en,
    // Watchdog
    input  wire logic                        i_wdt_overflow,
    input  wire logic                        i_wdt_en_wr,
    input  wire logic                        i_wdt_en_val,
    output logic                             o_wdt_enable,
    output logic                             o_wdt_tick,
    // Flash access checker
    input  rsc_pkg::rsc_flash_t              i_flash,
    input  wire logic [rsc_pkg::RSC_ADDR_W-1:0] i_lock_addr,
    // Real-time clock block
    input  rsc_pkg::rsc_rtc_t                i_rtc,
    // Clock loss, supply, pin, power state
    input  wire logic                        i_clk_missing,
    input  wire logic                        i_vdd_low,
    input  wire logic                        i_rst_pin_n,
    input  wire logic                        i_low_power,
    // Reset and status outputs
    output logic                             o_sys_rst_n,
    output logic                             o_mcd_enable,
    output logic                             o_vdm_enable,
    output rsc_pkg::rsc_cause_t              o_cause
);
    localparam int HW = $clog2(HOLD_CYC + 1);
    localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYC - 1);

    if (HOLD_CYC < 1) begin : g_chk
        $error("Reset hold must last at least one cycle.");
    end

    rsc_pkg::rsc_state_t state_reg;
    rsc_pkg::rsc_state_t state_next;
    logic [HW-1:0]       hold_reg;
    logic [HW-1:0]       hold_next;
    rsc_pkg::rsc_cause_t cause_reg;
    logic                cmp_en_reg;
    logic                rtc_en_reg;
    logic                mcd_en_reg;
    logic                vdm_en_reg;
    logic [7:0]          rdata_reg;

    rsc_pkg::rsc_cause_t req;
    rsc_pkg::rsc_cause_t win;
    rsc_pkg::rsc_cause_t wbits;
    logic                wdt_active;

    // Register access decode.
    wire sfr_hit = (i_sfr.addr == rsc_pkg::RSC_SFR_ADDR);
    wire wr_hit  = sfr_hit & i_sfr.wr;
    wire rd_hit  = sfr_hit & i_sfr.rd;
    assign wbits = rsc_pkg::rsc_cause_t'(i_sfr.wdata);

    // Low-power gating of individual sources.
    wire awake   = ~i_low_power;
    wire cmp_ok  = awake | i_cmp_wake_en;

    // Flash illegal-access detection.
    wire fl_wr_hi  = i_flash.wr_en & i_flash.xdata_wr
                   & (i_flash.xdata_addr > i_lock_addr);
    wire fl_rd_hi  = (i_flash.code_rd | i_flash.branch)
                   & (i_flash.code_addr > i_lock_addr);
    wire fl_nomon  = i_flash.wr_erase & ~vdm_en_reg;
    wire fl_fault  = fl_wr_hi | fl_rd_hi | i_flash.sec_block | fl_nomon;

    // Real-time clock block events.
    wire rtc_fail  = i_rtc.mcd_en & i_rtc.clk_slow;
    wire rtc_alarm = i_rtc.alarm_en & (i_rtc.timer == i_rtc.alarm);

    // Request vector, one field per source.
    always_comb begin
        req       = rsc_pkg::RSC_CAUSE_NONE;
        req.pin   = ~i_rst_pin_n;
        req.por   = vdm_en_reg & i_vdd_low;
        req.clock_loss_detector   = mcd_en_reg & awake & i_clk_missing;
        req.wdt   = wdt_active & i_wdt_overflow;
        req.flash = fl_fault;
        req.sw    = wr_hit & wbits.sw;
        req.cmp   = cmp_en_reg & cmp_ok & ~i_cmp_out;
        req.rtc   = rtc_en_reg & (rtc_fail | rtc_alarm);
    end

    wire any_req  = |req;
    wire hold_end = (hold_reg == HOLD_LAST);
    wire enter    = (state_reg == rsc_pkg::RSC_ST_RUN) & any_req;

    rsc_cause_pick u_pick (
        .i_req  (req),
        .o_pick (win)
    );

    // The pin keeps the hold going for as long as it stays low.
    always_comb begin
        state_next = state_reg;
        hold_next  = hold_reg;
        case (state_reg)
            rsc_pkg::RSC_ST_RUN: begin
                if (any_req) begin
                    state_next = rsc_pkg::RSC_ST_HOLD;
                    hold_next  = '0;
                end
            end
            rsc_pkg::RSC_ST_HOLD: begin
                if (!i_rst_pin_n) begin
                    hold_next = '0;
                end else if (hold_end) begin
                    state_next = rsc_pkg::RSC_ST_RUN;
                end else begin
                    hold_next = hold_reg + 1'b1;
                end
            end
            default: begin
                state_next = rsc_pkg::RSC_ST_HOLD;
                hold_next  = '0;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            state_reg <= rsc_pkg::RSC_ST_HOLD;
            hold_reg  <= '0;
        end else begin
            state_reg <= state_next;
            hold_reg  <= hold_next;
        end
    end

    // Cause flags change only when a new reset is taken, so software
    // sees the last cause until the next reset.
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            cause_reg <= rsc_pkg::RSC_CAUSE_POR;
        end else if (enter) begin
            cause_reg <= win;
        end
    end

    // Enables. The comparator, clock-block and clock-loss enables are all
    // cleared by any reset so that a persisting condition does not loop; software re-arms.
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            cmp_en_reg <= 1'b0;
            rtc_en_reg <= 1'b0;
            mcd_en_reg <= 1'b0;
            vdm_en_reg <= 1'b1;
        end else if (enter) begin
            cmp_en_reg <= 1'b0;
            rtc_en_reg <= 1'b0;
            mcd_en_reg <= 1'b0;
            vdm_en_reg <= vdm_en_reg | win.por;
        end else if (wr_hit) begin
            cmp_en_reg <= wbits.cmp;
            rtc_en_reg <= wbits.rtc;
            mcd_en_reg <= wbits.clock_loss_detector;
            vdm_en_reg <= wbits.por;
        end
    end

    // Flag bits 6, 3 and 0 have no write path, so read-modify-write
    // cycles cannot disturb them.
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            rdata_reg <= rsc_pkg::RSC_RDATA_IDLE;
        end else if (rd_hit) begin
            rdata_reg <= cause_reg;
        end else begin
            rdata_reg <= rsc_pkg::RSC_RDATA_IDLE;
        end
    end

    rsc_wdt_clock #(
        .DIV (WDT_DIV)
    ) u_wdt (
        .i_clock     (i_clock),
        .i_nrst      (i_nrst),
        .i_sys_rst   (enter),
        .i_en_wr     (i_wdt_en_wr),
        .i_en_val    (i_wdt_en_val),
        .i_low_power (i_low_power),
        .o_enable    (o_wdt_enable),
        .o_active    (wdt_active),
        .o_tick      (o_wdt_tick)
    );

    // Only the system reset is driven; the reset pin is input only.
    assign o_sys_rst_n  = (state_reg == rsc_pkg::RSC_ST_RUN);
    assign o_mcd_enable = mcd_en_reg & awake;
    assign o_vdm_enable = vdm_en_reg;
    assign o_sfr_rdata  = rdata_reg;
    assign o_cause      = cause_reg;
endmodule

// ### tb/rsc_far_model.sv
`timescale 1ns/100ps
module rsc_far_model (
    // Command, one bit a source in cause order
    input  wire logic [7:0]     i_cmd,
    // Source lines
    output logic                o_cmp_out,
    output logic                o_wdt_overflow,
    output logic                o_clk_missing,
    output logic                o_vdd_low,
    output logic                o_rst_pin_n,
    output rsc_pkg::rsc_flash_t o_flash,
    output rsc_pkg::rsc_rtc_t   o_rtc
);
    // Output rests high and settled, so enabling it never trips a reset.
    assign o_cmp_out      = !i_cmd[5];
    assign o_wdt_overflow = i_cmd[3];
    assign o_clk_missing  = i_cmd[2];
    // Supply is taken as stable from the start, so enabling it is safe.
    assign o_vdd_low      = i_cmd[1];
    assign o_rst_pin_n    = !i_cmd[0];
    // Bit 7 with bit 6 turns the flash write into a code read above the lock.
    assign o_flash = '{wr_en: i_cmd[6], xdata_wr: i_cmd[6] & ~i_cmd[7], xdata_addr: 16'h7c01,
                       code_rd: i_cmd[6] & i_cmd[7], branch: 1'b0, code_addr: 16'h7c01,
                       sec_block: 1'b0, wr_erase: i_cmd[6] & ~i_cmd[7]};
    // The alarm differs from the timer by one unless a match is commanded.
    // Bit 7 with bit 2 turns the alarm into an oscillator fail instead.
    assign o_rtc = '{mcd_en: i_cmd[7] & i_cmd[2], clk_slow: i_cmd[7] & i_cmd[2],
                     alarm_en: i_cmd[7] & ~i_cmd[2],
                     timer: 32'h0000_0010, alarm: i_cmd[7] ? 32'h0000_0010 : 32'h0000_0011};
endmodule

// ### tb/rsc_monitor.sv
`timescale 1ns/100ps
module rsc_monitor #(
    parameter int HOLD_CYC = rsc_pkg::RSC_HOLD_CYC
) (
    // Clock and reset
    input  wire logic           i_clock,
    input  wire logic           i_nrst,
    // Inputs watched
    input  rsc_pkg::rsc_sfr_t   i_sfr,
    input  wire logic           i_cmp_out,
    input  wire logic           i_wdt_overflow,
    input  wire logic           i_low_power,
    // Outputs watched
    input  wire logic           o_wdt_enable,
    input  wire logic           o_wdt_tick,
    input  wire logic           o_sys_rst_n,
    input  wire logic           o_mcd_enable,
    input  wire logic           o_vdm_enable,
    input  rsc_pkg::rsc_cause_t o_cause
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    wire sw_wr = i_sfr.wr && i_sfr.addr == 8'hef && i_sfr.wdata[4];
    property p_sw;
        sw_wr && o_sys_rst_n |=> !o_sys_rst_n && $onehot(o_cause);
    endproperty
    a_sw: assert property (p_sw) else $error("software write gave no reset");
    // Only two low cycles are checked, so HOLD_CYC must be two or more.
    property p_hold;
        $fell(o_sys_rst_n) |-> !o_sys_rst_n ##1 !o_sys_rst_n;
    endproperty
    a_hold: assert property (p_hold) else $error("reset pulse too short");
    // Low cycles are counted so that any hold length can be checked.
    int low_n;
    always_ff @(posedge i_clock) begin
        low_n <= o_sys_rst_n ? 0 : low_n + 1;
    end
    property p_hold_len;
        $rose(o_sys_rst_n) |-> low_n >= HOLD_CYC;
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("reset hold shorter than set");
    property p_one;
        o_sys_rst_n |-> $onehot(o_cause);
    endproperty
    a_one: assert property (p_one) else $error("cause not single");
    property p_tick;
        o_wdt_tick |=> !o_wdt_tick [*8];
    endproperty
    a_tick: assert property (p_tick) else $error("watchdog tick too fast");
    property p_wdt_up;
        $rose(o_sys_rst_n) |-> o_wdt_enable;
    endproperty
    a_wdt_up: assert property (p_wdt_up) else $error("watchdog off after reset");
    property p_cmp;
        $fell(o_sys_rst_n) && o_cause.cmp |-> !$past(i_cmp_out);
    endproperty
    a_cmp: assert property (p_cmp) else $error("comparator flag without cause");
    property p_wdt;
        $fell(o_sys_rst_n) && o_cause.wdt |-> $past(i_wdt_overflow) && !$past(i_low_power);
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog flag without cause");
    property p_mcd_lp;
        i_low_power ##1 i_low_power |-> !o_mcd_enable;
    endproperty
    a_mcd_lp: assert property (p_mcd_lp) else $error("clock detector on in sleep");
    property p_vdm;
        $rose(o_sys_rst_n) && o_cause.por |-> o_vdm_enable;
    endproperty
    a_vdm: assert property (p_vdm) else $error("supply monitor off after power reset");
    c_sw: cover property (sw_wr && o_sys_rst_n);
    c_cmp: cover property ($fell(o_sys_rst_n) && o_cause.cmp);
    c_lp: cover property (i_low_power && o_cause.cmp && $fell(o_sys_rst_n));
endmodule
bind rsc_reset_source_controller rsc_monitor #(.HOLD_CYC(HOLD_CYC)) mon_u (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_sfr(i_sfr), .i_cmp_out(i_cmp_out),
    .i_wdt_overflow(i_wdt_overflow), .i_low_power(i_low_power),
    .o_wdt_enable(o_wdt_enable), .o_wdt_tick(o_wdt_tick), .o_sys_rst_n(o_sys_rst_n),
    .o_mcd_enable(o_mcd_enable), .o_vdm_enable(o_vdm_enable), .o_cause(o_cause));

// ### tb/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic                i_clock = 1'b0;
    logic                i_nrst  = 1'b0;
    rsc_pkg::rsc_sfr_t   sfr     = '0;
    logic                low_pw  = 1'b0;
    logic                wake_en = 1'b0;
    logic [7:0]          cmd     = 8'h00;
    logic                wdt_wr  = 1'b0;
    logic                wdt_val = 1'b0;
    logic [7:0]          rdata;
    logic                sys_n, wdt_en, vdm_en, cmp_o, wdt_o, miss, vlow, pin_n;
    rsc_pkg::rsc_flash_t flash;
    rsc_pkg::rsc_rtc_t   rtc;
    rsc_pkg::rsc_cause_t cause;
    int                  fails = 0, check_count = 0, cycles = 0;
    logic [7:0]          en_tab [7] = '{8'h82, 8'h02, 8'h22, 8'h02, 8'h06, 8'h02, 8'h02};
    logic [7:0]          src_tab [7] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h04, 8'h01, 8'h02};
    rsc_far_model far_u (.i_cmd(cmd), .o_cmp_out(cmp_o), .o_wdt_overflow(wdt_o),
        .o_clk_missing(miss), .o_vdd_low(vlow), .o_rst_pin_n(pin_n), .o_flash(flash),
        .o_rtc(rtc));
    rsc_reset_source_controller #(.HOLD_CYC(2), .WDT_DIV(12)) dut_u (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_sfr(sfr), .o_sfr_rdata(rdata),
        .i_cmp_out(cmp_o), .i_cmp_wake_en(wake_en), .i_wdt_overflow(wdt_o),
        .i_wdt_en_wr(wdt_wr), .i_wdt_en_val(wdt_val), .o_wdt_enable(wdt_en), .o_wdt_tick(),
        .i_flash(flash), .i_lock_addr(16'h7c00), .i_rtc(rtc), .i_clk_missing(miss),
        .i_vdd_low(vlow), .i_rst_pin_n(pin_n), .i_low_power(low_pw), .o_sys_rst_n(sys_n),
        .o_mcd_enable(), .o_vdm_enable(vdm_en), .o_cause(cause));
    always #50 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            close_out();
        end
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            fails++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(negedge i_clock);
        sfr = '0;
        @(negedge i_clock);
    endtask
    task automatic wdt_set(input logic v);
        wdt_wr  = 1'b1;
        wdt_val = v;
        @(negedge i_clock);
        wdt_wr  = 1'b0;
        @(negedge i_clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        sfr = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge i_clock);
        sfr = '0;
        check("read data", rdata, exp);
        @(negedge i_clock);
    endtask
    task automatic wait_rst(input logic lvl);
        int n;
        n = 0;
        while (sys_n !== lvl && n < 50) begin
            @(negedge i_clock);
            n++;
        end
        check("reset level", {7'h00, sys_n}, {7'h00, lvl});
    endtask
    // Six quiet cycles is far beyond the one-cycle reset answer.
    task automatic quiet;
        repeat (6) begin
            @(negedge i_clock);
            check("held off", {7'h00, sys_n}, 8'h01);
        end
    endtask
    task automatic fire(input logic [7:0] en, input logic [7:0] c, input logic [7:0] exp);
        if (en != 8'h00) wr(8'hef, en);
        cmd = c;
        wait_rst(1'b0);
        cmd = 8'h00;
        wait_rst(1'b1);
        rd(8'hef, exp);
        check("cause", cause, exp);
        check("watchdog enable", {7'h00, wdt_en}, 8'h01);
    endtask
    task automatic close_out;
        $display("Checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge i_clock);
        i_nrst = 1'b1;
        wait_rst(1'b1);
        check("power cause", cause, 8'h02);
        check("supply enable", {7'h00, vdm_en}, 8'h01);
        rd(8'hef, 8'h02);
        rd(8'hee, 8'h00);
        fire(8'h12, 8'h00, 8'h10);
        wr(8'hef, 8'h4b);
        quiet();
        rd(8'hef, 8'h10);
        cmd = 8'h20;
        quiet();
        cmd = 8'h00;
        for (int k = 0; k < 7; k++) begin
            fire(en_tab[k], src_tab[k], src_tab[k]);
        end
        fire(8'h02, 8'hc0, 8'h40);
        fire(8'h82, 8'h84, 8'h80);
        wr(8'hef, 8'h22);
        low_pw = 1'b1;
        cmd = 8'h20;
        quiet();
        wake_en = 1'b1;
        fire(8'h00, 8'h20, 8'h20);
        wake_en = 1'b0;
        fire(8'h82, 8'h80, 8'h80);
        wr(8'hef, 8'h06);
        cmd = 8'h0c;
        quiet();
        low_pw = 1'b0;
        fire(8'h00, 8'h0c, 8'h04);
        wdt_set(1'b0);
        check("watchdog off", {7'h00, wdt_en}, 8'h00);
        cmd = 8'h08;
        low_pw = 1'b1;
        quiet();
        low_pw = 1'b0;
        quiet();
        cmd = 8'h00;
        fire(8'h12, 8'h00, 8'h10);
        low_pw = 1'b1;
        cmd = 8'h08;
        quiet();
        low_pw = 1'b0;
        fire(8'h00, 8'h08, 8'h08);
        close_out();
    end
endmodule
